// ===== logic/pmbcfg_regs.sv
// Function
// RULE1 - the input status byte carries overvoltage in bit 7, undervoltage in bit 4 and low-input unit-off in bit 3, each clearable, other bits zero.
// RULE2 - the temperature status byte carries overtemperature fault in bit 7 and warning in bit 6, each clearable, bits 5 to 0 zero.
// RULE3 - the communication status byte sets bit 7 on an unknown command, bit 6 on invalid data and bit 5 on a checksum failure, other bits zero.
// RULE4 - the read gain trims default to 0x2000 and only values from 0x1999 to 0x2666 are accepted, the current gain included.
// RULE5 - offset trims only accept words whose exponent is -12 for output voltage, -3 for input voltage and -4 for current.
// RULE6 - every gain and offset trim write is refused while write protect is on, and the trims are kept as stored factors.
// RULE7 - bit 1 of the module type low byte is the write protect enable, bit 0 and the high byte read zero.
// RULE8 - bits 7 to 2 of the module type low byte hold a six-bit name whose top bit marks an isolated design.
// RULE9 - the firmware revision is read only and returns four BCD nibbles: major, minor, build high, build low.
// RULE10 - with bit 4 clear the device keeps its resistor address, with it set it answers only the alert response address while alerting.
// reset loads the alert response address here even with bit 4 clear; the resistor address follows at the first edge after release.
// RULE11 - bits 3 to 0 pick the pin functions: 0000 on/off and power good, 0001 trim and power good, 0010 trim and on/off.
// RULE12 - on the load-sharing variant the pin assignment stays 0000 and other codes are refused.
// RULE13 - the four telemetry commands are read-only words returning the latest measurement, and writing them is an unsupported command.
`timescale 1ns/1ps
`default_nettype none
module pmbcfg_regs
	import pmbcfg_pkg::*;
#(
	parameter logic [15:0] FW_REV      = 16'h0000,
	// arbitrary name code, top bit set for an isolated design
	parameter logic [5:0]  MODULE_NAME = 6'h2d
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rst_n,
	input  wire logic                   reqValid,
	input  wire logic                   reqWrite,
	input  wire logic [7:0]             reqCode,
	input  wire logic [15:0]            reqData,
	input  wire logic                   reqPecOk,
	output var  logic                   rspValid_q,
	output var  logic [15:0]            rdData_q,
	input  wire logic                   vinOvEvt,
	input  wire logic                   vinUvEvt,
	input  wire logic                   lowVinOffEvt,
	input  wire logic                   otFaultEvt,
	input  wire logic                   otWarnEvt,
	input  wire logic [15:0]            vinMeas,
	input  wire logic [15:0]            voutMeas,
	input  wire logic [15:0]            ioutMeas,
	input  wire logic [15:0]            tempMeas,
	input  wire logic                   loadShareStrap,
	input  wire logic                   smbAlertActive,
	input  wire logic [6:0]             resistorAddr,
	output var  logic [6:0]             respondAddr_q,
	output var  logic                   writeProtect_q,
	output var  pmbcfg_pinfunc_t        pin1Func_q,
	output var  pmbcfg_pinfunc_t        pin2Func_q
);

	// ==========================================================
	// request decode
	logic        cmdKnown;
	logic        cmdReadOnly;
	logic        wrReq;
	logic        rdReq;
	logic        badCmd;
	logic        pecBad;
	logic        wrOk;
	logic        trimHit;
	logic [2:0]  trimIdx;
	logic        trimDataOk;
	logic        trimWe;
	logic        cfgHit;
	logic        cfgDataOk;
	logic        cfgWe;
	logic        dataBad;
	logic        araEn_q;
	logic [3:0]  pinAssign_q;
	logic        loadShare_q;
	logic        strapTaken_q;
	logic        rdPend_q;
	logic [7:0]  rdCode_q;
	logic [15:0] trimRd;
	logic [7:0]  inFlags;
	logic [7:0]  tempFlags;
	logic [7:0]  commFlags;
	logic [7:0]  inSet;
	logic [7:0]  tempSet;
	logic [7:0]  commSet;
	logic [7:0]  inClr;
	logic [7:0]  tempClr;
	logic [15:0] rdData_d;

	always_comb begin
		cmdKnown    = 1'b1;
		cmdReadOnly = 1'b0;
		case (reqCode)
			CMD_COMM_STATUS, CMD_INPUT_STATUS, CMD_TEMP_STATUS: begin
				cmdReadOnly = 1'b0;
			end
			CMD_INPUT_VOLTAGE_READING, CMD_READ_VOUT, CMD_READ_IOUT, CMD_READ_TEMP: begin
				cmdReadOnly = 1'b1; // RULE13
			end
			CMD_FW_REV: begin
				cmdReadOnly = 1'b1; // RULE9
			end
			CMD_MODULE_TYPE, CMD_ALERT_PIN: begin
				cmdReadOnly = 1'b0;
			end
			default: begin
				cmdKnown = is_trim(reqCode);
			end
		endcase
	end

	assign wrReq   = reqValid && reqWrite;
	assign rdReq   = reqValid && !reqWrite;
	assign badCmd  = reqValid && (!cmdKnown || (reqWrite && cmdReadOnly)); // RULE13
	assign pecBad  = wrReq && cmdKnown && !cmdReadOnly && !reqPecOk;
	assign wrOk    = wrReq && cmdKnown && !cmdReadOnly && reqPecOk;

	assign trimHit    = is_trim(reqCode);
	assign trimIdx    = trim_index(reqCode);
	assign trimDataOk = trim_data_ok(trimIdx, reqData); // RULE4 RULE5
	assign trimWe     = wrOk && trimHit && trimDataOk && !writeProtect_q; // RULE6

	// the variant may only ever hold the default assignment
	assign cfgHit    = (reqCode == CMD_ALERT_PIN);
	assign cfgDataOk = (reqData[3:0] == ASSIGN_ONOFF_PG) ||
		(!loadShare_q && ((reqData[3:0] == ASSIGN_TRIM_PG) ||
		(reqData[3:0] == ASSIGN_TRIM_ONF))); // RULE11 RULE12
	assign cfgWe     = wrOk && cfgHit && cfgDataOk;

	// protected trim writes report as invalid data so software sees the refusal
	assign dataBad = wrOk && ((trimHit && (!trimDataOk || writeProtect_q)) ||
		(cfgHit && !cfgDataOk)); // RULE6

	// ==========================================================
	// status bytes
	always_comb begin
		inSet                 = BYTE_ZERO;
		inSet[IN_OV_BIT]      = vinOvEvt;
		inSet[IN_UV_BIT]      = vinUvEvt;
		inSet[IN_OFF_BIT]     = lowVinOffEvt; // RULE1
		tempSet               = BYTE_ZERO;
		tempSet[OT_FAULT_BIT] = otFaultEvt;
		tempSet[OT_WARN_BIT]  = otWarnEvt; // RULE2
		commSet               = BYTE_ZERO;
		commSet[COMM_CMD_BIT] = badCmd;
		commSet[COMM_DATA_BIT] = dataBad;
		commSet[COMM_PEC_BIT] = pecBad; // RULE3
	end

	assign inClr   = (wrOk && (reqCode == CMD_INPUT_STATUS)) ? reqData[7:0] : BYTE_ZERO;
	assign tempClr = (wrOk && (reqCode == CMD_TEMP_STATUS)) ? reqData[7:0] : BYTE_ZERO;

	pmbcfg_flag_byte #(
		.IMPL    (IN_IMPL_MASK)
	) u_input_flags (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.setEvt  (inSet),
		.clrMask (inClr),
		.flags_q (inFlags)
	); // RULE1

	pmbcfg_flag_byte #(
		.IMPL    (TEMP_IMPL_MASK)
	) u_temp_flags (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.setEvt  (tempSet),
		.clrMask (tempClr),
		.flags_q (tempFlags)
	); // RULE2

	pmbcfg_flag_byte #(
		.IMPL    (COMM_IMPL_MASK)
	) u_comm_flags (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.setEvt  (commSet),
		.clrMask ((wrOk && (reqCode == CMD_COMM_STATUS)) ? reqData[7:0] : BYTE_ZERO),
		.flags_q (commFlags)
	); // RULE3

	// ==========================================================
	// calibration trims
	pmbcfg_trim_mem #(
		.WIDTH    (TRIM_W),
		.DEPTH    (TRIM_DEPTH),
		.AW       (TRIM_AW),
		.INIT     (TRIM_INIT)
	) u_trims (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.we       (trimWe),
		.wrAddr   (trimIdx),
		.wrData   (reqData),
		.rdAddr   (trimIdx),
		.rdData_q (trimRd)
	); // RULE4 RULE6

	// ==========================================================
	// module type, write protect
	// the name code is fixed; only the protect bit takes a write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			writeProtect_q <= MT_WPE_DEFAULT;
		end else if (wrOk && (reqCode == CMD_MODULE_TYPE)) begin
			writeProtect_q <= reqData[MT_WPE_BIT]; // RULE7
		end
	end

	// ==========================================================
	// alert and pin configuration
	// strap caught on the first edge after release, never by the reset itself
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			loadShare_q  <= 1'b0;
			strapTaken_q <= 1'b0;
		end else if (!strapTaken_q) begin
			loadShare_q  <= loadShareStrap;
			strapTaken_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			araEn_q     <= 1'b0;
			pinAssign_q <= ASSIGN_ONOFF_PG;
		end else if (!strapTaken_q && loadShareStrap) begin
			pinAssign_q <= ASSIGN_ONOFF_PG; // RULE12
		end else if (cfgWe) begin
			araEn_q     <= reqData[CFG_ARA_BIT];
			pinAssign_q <= reqData[3:0]; // RULE11
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			respondAddr_q <= ARA_ADDR;
		end else if (araEn_q && smbAlertActive) begin
			respondAddr_q <= ARA_ADDR; // RULE10
		end else begin
			respondAddr_q <= resistorAddr; // RULE10
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin1Func_q <= PF_ONOFF;
			pin2Func_q <= PF_PGOOD;
		end else begin
			case (pinAssign_q)
				ASSIGN_TRIM_PG: begin
					pin1Func_q <= PF_TRIM;
					pin2Func_q <= PF_PGOOD;
				end
				ASSIGN_TRIM_ONF: begin
					pin1Func_q <= PF_TRIM;
					pin2Func_q <= PF_ONOFF;
				end
				default: begin
					pin1Func_q <= PF_ONOFF;
					pin2Func_q <= PF_PGOOD;
				end
			endcase // RULE11
		end
	end

	// ==========================================================
	// read path: the trim store answers one edge late, so every read
	// answers one edge after it is taken to keep the timing uniform
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdPend_q <= 1'b0;
			rdCode_q <= BYTE_ZERO;
		end else begin
			rdPend_q <= rdReq;
			rdCode_q <= reqCode;
		end
	end

	always_comb begin
		rdData_d = {BYTE_ZERO, BYTE_ZERO};
		case (rdCode_q)
			CMD_INPUT_STATUS: rdData_d = {BYTE_ZERO, inFlags};
			CMD_TEMP_STATUS:  rdData_d = {BYTE_ZERO, tempFlags};
			CMD_COMM_STATUS:  rdData_d = {BYTE_ZERO, commFlags};
			CMD_INPUT_VOLTAGE_READING:     rdData_d = vinMeas; // RULE13
			CMD_READ_VOUT:    rdData_d = voutMeas;
			CMD_READ_IOUT:    rdData_d = ioutMeas;
			CMD_READ_TEMP:    rdData_d = tempMeas;
			CMD_MODULE_TYPE:  rdData_d = {BYTE_ZERO, MODULE_NAME, writeProtect_q, 1'b0}; // RULE7 RULE8
			CMD_FW_REV:       rdData_d = FW_REV; // RULE9
			CMD_ALERT_PIN:    rdData_d = {BYTE_ZERO, 3'h0, araEn_q, pinAssign_q};
			default: begin
				if (is_trim(rdCode_q)) begin
					rdData_d = trimRd;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rspValid_q <= 1'b0;
			rdData_q   <= 16'h0000;
		end else begin
			rspValid_q <= rdPend_q;
			if (rdPend_q) begin
				rdData_q <= rdData_d;
			end
		end
	end

endmodule
`default_nettype wire

// ===== inc/pmbcfg_pkg.sv
`default_nettype none
package pmbcfg_pkg;

	// ==========================================================
	// command codes
	localparam logic [7:0] CMD_COMM_STATUS  = 8'h7a;
	localparam logic [7:0] CMD_INPUT_STATUS = 8'h7c;
	localparam logic [7:0] CMD_TEMP_STATUS  = 8'h7d;
	localparam logic [7:0] CMD_INPUT_VOLTAGE_READING     = 8'h88;
	localparam logic [7:0] CMD_READ_VOUT    = 8'h8b;
	localparam logic [7:0] CMD_READ_IOUT    = 8'h8c;
	localparam logic [7:0] CMD_READ_TEMP    = 8'h8d;
	localparam logic [7:0] CMD_MODULE_TYPE  = 8'hd0;
	localparam logic [7:0] CMD_VOUT_GAIN    = 8'hd1;
	localparam logic [7:0] CMD_VOUT_OFS     = 8'hd2;
	localparam logic [7:0] CMD_VIN_GAIN     = 8'hd3;
	localparam logic [7:0] CMD_VIN_OFS      = 8'hd4;
	localparam logic [7:0] CMD_IOUT_GAIN    = 8'hd6;
	localparam logic [7:0] CMD_IOUT_OFS     = 8'hd7;
	localparam logic [7:0] CMD_FW_REV       = 8'hdb;
	localparam logic [7:0] CMD_ALERT_PIN    = 8'he0;

	// ==========================================================
	// status byte layouts
	localparam int         IN_OV_BIT      = 7;
	localparam int         IN_UV_BIT      = 4;
	localparam int         IN_OFF_BIT     = 3;
	localparam int         OT_FAULT_BIT   = 7;
	localparam int         OT_WARN_BIT    = 6;
	localparam int         COMM_CMD_BIT   = 7;
	localparam int         COMM_DATA_BIT  = 6;
	localparam int         COMM_PEC_BIT   = 5;
	localparam logic [7:0] IN_IMPL_MASK   = 8'h98;
	localparam logic [7:0] TEMP_IMPL_MASK = 8'hc0;
	localparam logic [7:0] COMM_IMPL_MASK = 8'he0;
	localparam logic [7:0] BYTE_ZERO      = 8'h00;

	// ==========================================================
	// calibration trims
	localparam int          TRIM_W        = 16;
	localparam int          TRIM_DEPTH    = 6;
	localparam int          TRIM_AW       = 3;
	localparam logic [15:0] GAIN_DEFAULT  = 16'h2000;
	localparam logic [15:0] GAIN_MIN      = 16'h1999;
	localparam logic [15:0] GAIN_MAX      = 16'h2666;
	localparam int          EXP_MSB       = 15;
	localparam int          EXP_LSB       = 11;
	localparam logic [4:0]  EXP_VOUT_OFS  = 5'h14;
	localparam logic [4:0]  EXP_VIN_OFS   = 5'h1d;
	localparam logic [4:0]  EXP_IOUT_OFS  = 5'h1c;
	localparam logic [10:0] MANT_ZERO     = 11'h000;
	localparam logic [2:0]  TRIM_VOUT_GAIN = 3'h0;
	localparam logic [2:0]  TRIM_VOUT_OFS  = 3'h1;
	localparam logic [2:0]  TRIM_VIN_GAIN  = 3'h2;
	localparam logic [2:0]  TRIM_VIN_OFS   = 3'h3;
	localparam logic [2:0]  TRIM_IOUT_GAIN = 3'h4;
	localparam logic [2:0]  TRIM_IOUT_OFS  = 3'h5;
	localparam logic [TRIM_DEPTH*TRIM_W-1:0] TRIM_INIT = {
		EXP_IOUT_OFS, MANT_ZERO, GAIN_DEFAULT,
		EXP_VIN_OFS, MANT_ZERO, GAIN_DEFAULT,
		EXP_VOUT_OFS, MANT_ZERO, GAIN_DEFAULT};

	// ==========================================================
	// module type and alert/pin configuration
	localparam int         MT_WPE_BIT      = 1;
	localparam int         MT_NAME_LSB     = 2;
	localparam logic       MT_WPE_DEFAULT  = 1'b1;
	localparam int         CFG_ARA_BIT     = 4;
	localparam logic [3:0] ASSIGN_ONOFF_PG = 4'h0;
	localparam logic [3:0] ASSIGN_TRIM_PG  = 4'h1;
	localparam logic [3:0] ASSIGN_TRIM_ONF = 4'h2;
	localparam logic [6:0] ARA_ADDR        = 7'h0c;

	typedef enum logic [1:0] {
		PF_ONOFF = 2'h0,
		PF_TRIM  = 2'h1,
		PF_PGOOD = 2'h3
	} pmbcfg_pinfunc_t;

	// ==========================================================
	// helpers
	function automatic logic gain_ok(input logic [15:0] w);
		return (w >= GAIN_MIN) && (w <= GAIN_MAX);
	endfunction

	function automatic logic [4:0] offset_exp(input logic [2:0] idx);
		logic [4:0] e;
		e = EXP_VOUT_OFS;
		if (idx == TRIM_VIN_OFS) begin
			e = EXP_VIN_OFS;
		end else if (idx == TRIM_IOUT_OFS) begin
			e = EXP_IOUT_OFS;
		end
		return e;
	endfunction

	function automatic logic trim_data_ok(input logic [2:0] idx, input logic [15:0] w);
		logic ok;
		ok = gain_ok(w);
		if (idx[0]) begin
			ok = (w[EXP_MSB:EXP_LSB] == offset_exp(idx));
		end
		return ok;
	endfunction

	function automatic logic [2:0] trim_index(input logic [7:0] code);
		logic [2:0] idx;
		idx = TRIM_VOUT_GAIN;
		case (code)
			CMD_VOUT_OFS:  idx = TRIM_VOUT_OFS;
			CMD_VIN_GAIN:  idx = TRIM_VIN_GAIN;
			CMD_VIN_OFS:   idx = TRIM_VIN_OFS;
			CMD_IOUT_GAIN: idx = TRIM_IOUT_GAIN;
			CMD_IOUT_OFS:  idx = TRIM_IOUT_OFS;
			default:       idx = TRIM_VOUT_GAIN;
		endcase
		return idx;
	endfunction

	function automatic logic is_trim(input logic [7:0] code);
		return (code == CMD_VOUT_GAIN) || (code == CMD_VOUT_OFS) ||
			(code == CMD_VIN_GAIN) || (code == CMD_VIN_OFS) ||
			(code == CMD_IOUT_GAIN) || (code == CMD_IOUT_OFS);
	endfunction

endpackage
`default_nettype wire

// ===== logic/pmbcfg_flag_byte.sv
`timescale 1ns/1ps
`default_nettype none
module pmbcfg_flag_byte #(
	parameter logic [7:0] IMPL = 8'hff
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] setEvt,
	input  wire logic [7:0] clrMask,
	output var  logic [7:0] flags_q
);
	// set is applied after the clear so an event in the clearing cycle survives
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= 8'h00;
		end else begin
			flags_q <= ((flags_q & ~clrMask) | setEvt) & IMPL;
		end
	end
endmodule
`default_nettype wire

// ===== logic/pmbcfg_trim_mem.sv
`timescale 1ns/1ps
`default_nettype none
module pmbcfg_trim_mem #(
	parameter int                     WIDTH = 16,
	parameter int                     DEPTH = 6,
	parameter int                     AW    = 3,
	parameter logic [DEPTH*WIDTH-1:0] INIT  = '0
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic             we,
	input  wire logic [AW-1:0]    wrAddr,
	input  wire logic [WIDTH-1:0] wrData,
	input  wire logic [AW-1:0]    rdAddr,
	output var  logic [WIDTH-1:0] rdData_q
);
	logic [WIDTH-1:0] mem [DEPTH];

	// stands in for the nonvolatile copy: reset reloads the stored defaults
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= INIT[i*WIDTH +: WIDTH];
			end
		end else if (we && (int'(wrAddr) < DEPTH)) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_q <= '0;
		end else if (int'(rdAddr) < DEPTH) begin
			rdData_q <= mem[rdAddr];
		end else begin
			rdData_q <= '0;
		end
	end
endmodule
`default_nettype wire

// ===== test/pmbcfg_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pmbcfg_regs_asserts
	import pmbcfg_pkg::*;
#(
	parameter logic [15:0] FW_REV = 16'h0000
) (
	input wire logic            sys_clk,
	input wire logic            rst_n,
	input wire logic            reqValid,
	input wire logic            reqWrite,
	input wire logic [7:0]      reqCode,
	input wire logic [15:0]     reqData,
	input wire logic            reqPecOk,
	input wire logic            rspValid_q,
	input wire logic [15:0]     rdData_q,
	input wire logic [15:0]     vinMeas,
	input wire logic            loadShareStrap,
	input wire logic            smbAlertActive,
	input wire logic [6:0]      resistorAddr,
	input wire logic [6:0]      respondAddr_q,
	input wire logic            writeProtect_q,
	input wire pmbcfg_pinfunc_t pin1Func_q,
	input wire pmbcfg_pinfunc_t pin2Func_q
);
	logic rdReq;
	logic wrMt;
	assign rdReq = reqValid && !reqWrite;
	assign wrMt  = reqValid && reqWrite && reqPecOk && (reqCode == CMD_MODULE_TYPE);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// ========
	// read path
	chk_read_answer: assert property (rdReq |-> ##2 rspValid_q)
		else $error("read answer missing");
	chk_no_stray: assert property (rspValid_q |-> $past(rdReq, 2))
		else $error("answer without a read");
	chk_fw_value: assert property (rdReq && reqCode == CMD_FW_REV |-> ##2 rdData_q == FW_REV)
		else $error("firmware revision wrong");
	chk_vin_value: assert property (rdReq && reqCode == CMD_INPUT_VOLTAGE_READING |-> ##2 rdData_q == $past(vinMeas))
		else $error("input voltage reading wrong");
	chk_rd_hold: assert property (!rspValid_q |-> $stable(rdData_q))
		else $error("read data changed without answer");

	// ========
	// protect, address and pins
	chk_wp_update: assert property (wrMt |=> writeProtect_q == $past(reqData[MT_WPE_BIT]))
		else $error("protect bit not written");
	chk_wp_steady: assert property (!wrMt |=> $stable(writeProtect_q))
		else $error("protect bit changed");
	chk_ara_off: assert property (!smbAlertActive |=> respondAddr_q == $past(resistorAddr))
		else $error("address not resistor value");
	chk_pin_pairs: assert property ((pin1Func_q == PF_ONOFF && pin2Func_q == PF_PGOOD) ||
		(pin1Func_q == PF_TRIM && pin2Func_q != PF_TRIM))
		else $error("illegal pin pair");
	chk_share_pins: assert property (loadShareStrap && $past(loadShareStrap) |->
		pin1Func_q == PF_ONOFF && pin2Func_q == PF_PGOOD)
		else $error("load share pins changed");
endmodule

bind pmbcfg_regs pmbcfg_regs_asserts #(.FW_REV(FW_REV)) pmbcfg_regs_asserts_inst (.sys_clk, .rst_n,
	.reqValid, .reqWrite, .reqCode, .reqData, .reqPecOk, .rspValid_q, .rdData_q, .vinMeas,
	.loadShareStrap, .smbAlertActive, .resistorAddr, .respondAddr_q, .writeProtect_q,
	.pin1Func_q, .pin2Func_q);
`default_nettype wire

// ===== test/pmbcfg_host.sv
`timescale 1ns/1ps
`default_nettype none
module pmbcfg_host (
	input  wire logic        sys_clk,
	output var  logic        reqValid,
	output var  logic        reqWrite,
	output var  logic [7:0]  reqCode,
	output var  logic [15:0] reqData,
	output var  logic        reqPecOk
);
	initial begin
		reqValid = 1'b0;
		{reqWrite, reqCode, reqData, reqPecOk} = '0;
	end

	// ========
	// caller enters just after an edge; request stands across the taking edge
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, input logic p);
		reqValid = 1'b1;
		reqWrite = w;
		reqCode  = c;
		reqData  = d;
		reqPecOk = p;
		@(posedge sys_clk);
		#1;
	endtask

	// released lines flip so a stale command can never pass for a live one
	task automatic idle();
		reqValid = 1'b0;
		{reqWrite, reqCode, reqData, reqPecOk} = ~{reqWrite, reqCode, reqData, reqPecOk};
	endtask
endmodule
`default_nettype wire

// ===== test/pmbcfg_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pmbcfg_regs_bench
	import pmbcfg_pkg::*;
();
	localparam logic [15:0] FW = 16'h0307;
	// arbitrary name code
	localparam logic [5:0]  MN = 6'h2d;
	localparam logic [7:0]  DCODE [12] = '{CMD_VOUT_GAIN, CMD_VIN_GAIN, CMD_IOUT_GAIN,
		CMD_VOUT_OFS, CMD_VIN_OFS, CMD_IOUT_OFS, CMD_MODULE_TYPE, CMD_FW_REV, CMD_ALERT_PIN,
		CMD_INPUT_STATUS, CMD_TEMP_STATUS, CMD_COMM_STATUS};
	localparam logic [15:0] DVAL [12] = '{16'h2000, 16'h2000, 16'h2000, 16'ha000, 16'he800,
		16'he000, {8'h00, MN, 2'b10}, FW, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	localparam logic [7:0]  GCODE [3] = '{CMD_VOUT_GAIN, CMD_VIN_GAIN, CMD_IOUT_GAIN};
	localparam logic [7:0]  OCODE [3] = '{CMD_VOUT_OFS, CMD_VIN_OFS, CMD_IOUT_OFS};
	localparam logic [4:0]  OEXP [3]  = '{5'h14, 5'h1d, 5'h1c};
	localparam logic [15:0] GVAL [5]  = '{16'h1999, 16'h1998, 16'h2666, 16'h2667, 16'h2000};

	logic            sys_clk;
	logic            rst_n;
	logic            reqValid;
	logic            reqWrite;
	logic [7:0]      reqCode;
	logic [15:0]     reqData;
	logic            reqPecOk;
	logic            rspValid_q;
	logic [15:0]     rdData_q;
	logic            vinOvEvt, vinUvEvt, lowVinOffEvt, otFaultEvt, otWarnEvt;
	logic [15:0]     vinMeas, voutMeas, ioutMeas, tempMeas;
	logic            loadShareStrap;
	logic            smbAlertActive;
	logic [6:0]      resistorAddr;
	logic [6:0]      respondAddr_q;
	logic            writeProtect_q;
	pmbcfg_pinfunc_t pin1Func_q;
	pmbcfg_pinfunc_t pin2Func_q;
	logic [15:0]     expQ [$];
	int              errTotal = 0;
	int              compares = 0;

	pmbcfg_regs #(.FW_REV(FW), .MODULE_NAME(MN)) pmbcfg_regs_inst (.sys_clk, .rst_n, .reqValid,
		.reqWrite, .reqCode, .reqData, .reqPecOk, .rspValid_q, .rdData_q, .vinOvEvt, .vinUvEvt,
		.lowVinOffEvt, .otFaultEvt, .otWarnEvt, .vinMeas, .voutMeas, .ioutMeas, .tempMeas,
		.loadShareStrap, .smbAlertActive, .resistorAddr, .respondAddr_q, .writeProtect_q,
		.pin1Func_q, .pin2Func_q);
	pmbcfg_host pmbcfg_host_inst (.sys_clk, .reqValid, .reqWrite, .reqCode, .reqData, .reqPecOk);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ========
	// helpers
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			errTotal++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic p = 1'b1);
		pmbcfg_host_inst.xfer(1'b1, c, d, p);
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		expQ.push_back(e);
		pmbcfg_host_inst.xfer(1'b0, c, 16'h0000, 1'b1);
	endtask
	// read the fault byte, then clear it for the next case
	task automatic flag(input logic [15:0] e);
		rd(CMD_COMM_STATUS, e);
		wr(CMD_COMM_STATUS, 16'h00ff);
	endtask
	// idle first so no answer is in flight when reset lands
	task automatic do_reset(input logic strap);
		pmbcfg_host_inst.idle();
		if (rst_n) step(3);
		rst_n = 1'b0;
		loadShareStrap = strap;
		step(6);
		rst_n = 1'b1;
		step(2);
	endtask
	task automatic tally_and_finish();
		if (errTotal == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		#2;
		if (rspValid_q === 1'b1) begin
			cmp("read data", (expQ.size() > 0) ? expQ.pop_front() : 'x, rdData_q);
		end
	end

	initial begin
		repeat (5000) @(posedge sys_clk);
		errTotal++;
		tally_and_finish();
	end

	// ========
	// main sequence
	initial begin
		logic [15:0] cur;
		logic [15:0] v;
		logic [10:0] m;
		logic        ok;
		rst_n = 1'b0;
		{vinOvEvt, vinUvEvt, lowVinOffEvt, otFaultEvt, otWarnEvt} = 5'h00;
		{smbAlertActive, loadShareStrap} = 2'b00;
		resistorAddr = 7'h25;
		void'($urandom(32'h59bc_1825));
		{vinMeas, voutMeas, ioutMeas, tempMeas} = {$urandom, $urandom};
		do_reset(1'b0);
		cmp("protect", 16'h0001, 16'(writeProtect_q));
		foreach (DCODE[i]) rd(DCODE[i], DVAL[i]);
		{vinMeas, voutMeas, ioutMeas, tempMeas} = {$urandom, $urandom};
		rd(CMD_INPUT_VOLTAGE_READING, vinMeas);
		rd(CMD_READ_VOUT, voutMeas);
		rd(CMD_READ_IOUT, ioutMeas);
		rd(CMD_READ_TEMP, tempMeas);
		wr(CMD_READ_VOUT, 16'h1234);
		flag(16'h0080);
		wr(CMD_VOUT_GAIN, 16'h2100);
		flag(16'h0040);
		wr(CMD_MODULE_TYPE, 16'hfffd, 1'b0);
		flag(16'h0020);
		rd(CMD_MODULE_TYPE, {8'h00, MN, 2'b10});
		wr(CMD_MODULE_TYPE, 16'hfffd);
		rd(CMD_MODULE_TYPE, {8'h00, MN, 2'b00});
		foreach (GCODE[i]) begin
			cur = 16'h2000;
			for (int j = 0; j < 6; j++) begin
				v = (j < 5) ? GVAL[j] : 16'h1999 + 16'($urandom_range(0, 16'h0ccd));
				ok = (v >= 16'h1999) && (v <= 16'h2666);
				cur = ok ? v : cur;
				wr(GCODE[i], v);
				flag(ok ? 16'h0000 : 16'h0040);
				rd(GCODE[i], cur);
			end
		end
		foreach (OCODE[i]) begin
			m = 11'($urandom);
			wr(OCODE[i], {OEXP[i], m});
			wr(OCODE[i], {OEXP[i] ^ 5'h01, ~m});
			flag(16'h0040);
			rd(OCODE[i], {OEXP[i], m});
		end
		wr(CMD_MODULE_TYPE, 16'h0002);
		wr(CMD_IOUT_OFS, 16'he000);
		flag(16'h0040);
		rd(CMD_IOUT_OFS, {OEXP[2], m});
		rd(8'h55, 16'h0000);
		flag(16'h0080);
		wr(CMD_FW_REV, 16'h9999);
		flag(16'h0080);
		pmbcfg_host_inst.idle();
		{vinOvEvt, vinUvEvt, lowVinOffEvt, otFaultEvt, otWarnEvt} = 5'h1f;
		step(1);
		{vinOvEvt, vinUvEvt, lowVinOffEvt, otFaultEvt, otWarnEvt} = 5'h00;
		rd(CMD_INPUT_STATUS, 16'h0098);
		rd(CMD_TEMP_STATUS, 16'h00c0);
		wr(CMD_INPUT_STATUS, 16'h0008);
		wr(CMD_TEMP_STATUS, 16'h0040);
		rd(CMD_INPUT_STATUS, 16'h0090);
		rd(CMD_TEMP_STATUS, 16'h0080);
		wr(CMD_INPUT_STATUS, 16'h00ff);
		wr(CMD_TEMP_STATUS, 16'h00ff);
		rd(CMD_INPUT_STATUS, 16'h0000);
		rd(CMD_TEMP_STATUS, 16'h0000);
		for (int c = 1; c < 4; c++) begin
			v = 16'(c % 3);
			wr(CMD_ALERT_PIN, v);
			pmbcfg_host_inst.idle();
			step(2);
			cmp("pin one", 16'((v != 0) ? PF_TRIM : PF_ONOFF), 16'(pin1Func_q));
			cmp("pin two", 16'((v == 2) ? PF_ONOFF : PF_PGOOD), 16'(pin2Func_q));
			rd(CMD_ALERT_PIN, v);
		end
		wr(CMD_ALERT_PIN, 16'h0013);
		flag(16'h0040);
		rd(CMD_ALERT_PIN, 16'h0000);
		// alert with the response-address bit clear must leave the resistor address
		pmbcfg_host_inst.idle();
		smbAlertActive = 1'b1;
		step(2);
		cmp("address", 16'(resistorAddr), 16'(respondAddr_q));
		smbAlertActive = 1'b0;
		wr(CMD_ALERT_PIN, 16'h0010);
		rd(CMD_ALERT_PIN, 16'h0010);
		pmbcfg_host_inst.idle();
		smbAlertActive = 1'b1;
		step(2);
		cmp("address", 16'h000c, 16'(respondAddr_q));
		resistorAddr = 7'($urandom);
		smbAlertActive = 1'b0;
		step(2);
		cmp("address", 16'(resistorAddr), 16'(respondAddr_q));
		do_reset(1'b1);
		wr(CMD_ALERT_PIN, 16'h0001);
		flag(16'h0040);
		rd(CMD_ALERT_PIN, 16'h0000);
		rd(CMD_VOUT_GAIN, 16'h2000);
		pmbcfg_host_inst.idle();
		step(4);
		cmp("pin one", 16'(PF_ONOFF), 16'(pin1Func_q));
		cmp("answers left", 16'h0000, 16'(expQ.size()));
		tally_and_finish();
	end
endmodule
`default_nettype wire
